// ===== hw/prsc_pkg.sv
// Package for the PLL reference switchover control block.
// Holds register offsets, field positions, reset values, states and bus carrier types.
// Assumes an Avalon-MM slave with a byte address and 32-bit data.
package prsc_pkg;

    // Byte addresses of the registers.
    localparam logic [7:0] PRSC_ADDR_CONTROL = 8'h1C;
    localparam logic [7:0] PRSC_ADDR_STATUS = 8'h20;

    // Field positions in the reference select control register.
    localparam int PRSC_BIT_DIFF_MODE = 0;
    localparam int PRSC_BIT_PRIMARY_PWR = 1;
    localparam int PRSC_BIT_SECONDARY_PWR = 2;
    localparam int PRSC_BIT_STAY_SECONDARY = 3;
    localparam int PRSC_BIT_AUTO_MODE = 4;
    localparam int PRSC_BIT_USE_PIN = 5;
    localparam int PRSC_BIT_SELECT_SECONDARY = 6;
    localparam int PRSC_BIT_DEGLITCH_OFF = 7;

    // Field positions in the status register.
    localparam int PRSC_STS_SELECTED = 0;
    localparam int PRSC_STS_PRIMARY_PWR = 1;
    localparam int PRSC_STS_SECONDARY_PWR = 2;
    localparam int PRSC_STS_AUTO_ON_SECONDARY = 3;
    localparam int PRSC_STS_CONFIG_CONFLICT = 4;
    localparam int PRSC_STS_PRIMARY_OK = 5;
    localparam int PRSC_STS_SECONDARY_OK = 6;

    // Reset value of the control register.
    localparam logic [7:0] PRSC_CONTROL_RESET = 8'h00;

    // Value returned for an unmapped read.
    localparam logic [31:0] PRSC_UNMAPPED_DATA = 32'h00000000;

    // Automatic switchover states, one-hot.
    typedef enum logic [1:0] {
        PRSC_ON_PRIMARY = 2'b01,
        PRSC_ON_SECONDARY = 2'b10
    } prsc_auto_state_e;

    // One accepted register write, valid for a single cycle.
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic lane0;
        logic [7:0] data;
    } prsc_bus_req_s;

endpackage

// ===== hw/prsc_avalon_slave.sv
// Avalon-MM handshake for the PLL reference switchover control block.
// Assumes a master that holds its request until it samples waitrequest low.
`timescale 1ns/10ps
module prsc_avalon_slave (
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] read_value,
    output logic [7:0] read_addr,
    output prsc_pkg::prsc_bus_req_s bus_req,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    import prsc_pkg::*;

    logic request;

    assign request = avs_read | avs_write;
    assign read_addr = avs_address;

    // Every request waits one cycle, then is answered at the following edge.
    always_ff @(posedge clock) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
        end else if (request && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    // Read data is captured one edge early so it stands when waitrequest is low.
    always_ff @(posedge clock) begin
        if (rst) begin
            avs_readdata <= PRSC_UNMAPPED_DATA;
        end else if (avs_read && avs_waitrequest) begin
            avs_readdata <= read_value;
        end
    end

    // A write takes effect only at the edge where waitrequest is sampled low.
    always_comb begin
        bus_req.wr = avs_write & ~avs_waitrequest;
        bus_req.addr = avs_address;
        bus_req.lane0 = avs_byteenable[0];
        bus_req.data = avs_writedata[7:0];
    end

endmodule // prsc_avalon_slave

// ===== hw/prsc_switchover.sv
// PLL reference switchover control: chooses the primary or secondary reference.
// Assumes Avalon-MM register access and status inputs synchronous to clock.
// Operation
// - Manual mode: method bit picks register or pin
// - Mode bit: zero manual by default, one automatic
// - Automatic mode powers both reference inputs on
// - Revert to primary unless stay bit set
// - Secondary power bit, default off, auto overrides
// - Register select bit: zero primary, one secondary
// - Primary power bit, default off, auto overrides
`timescale 1ns/10ps
module prsc_switchover (
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic ref_sel_pin,
    input wire logic primary_status_ok,
    input wire logic secondary_status_ok,
    output logic use_secondary_reference,
    output logic primary_reference_power,
    output logic secondary_reference_power
);
    import prsc_pkg::*;

    logic [7:0] pll_reference_select_control;
    prsc_auto_state_e auto_state;
    prsc_auto_state_e next_auto_state;
    prsc_bus_req_s bus_req;
    logic [7:0] read_addr;
    logic [31:0] read_value;
    logic auto_mode;
    logic stay_secondary;
    logic next_use_secondary;
    logic config_conflict;
    logic [7:0] status_word;

    // Register read decode; unmapped addresses read as zero.
    function automatic logic [31:0] read_decode(
        input logic [7:0] addr,
        input logic [7:0] control,
        input logic [7:0] status
    );
        logic [31:0] value;
        value = PRSC_UNMAPPED_DATA;
        if (addr == PRSC_ADDR_CONTROL) begin
            value = {24'h000000, control};
        end else if (addr == PRSC_ADDR_STATUS) begin
            value = {24'h000000, status};
        end
        return value;
    endfunction

    // Bus handshake and read data capture.
    prsc_avalon_slave u_slave (
        .clock(clock),
        .rst(rst),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable),
        .read_value(read_value),
        .read_addr(read_addr),
        .bus_req(bus_req),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest)
    );

    // Field decode of the control register.
    assign auto_mode = pll_reference_select_control[PRSC_BIT_AUTO_MODE];
    assign stay_secondary = pll_reference_select_control[PRSC_BIT_STAY_SECONDARY];

    // Automatic mode relies on single-ended mode; flag a bad setup for software.
    assign config_conflict = auto_mode
        & pll_reference_select_control[PRSC_BIT_DIFF_MODE];

    // Status word seen by software, one flag per field position.
    always_comb begin
        status_word = 8'h00;
        status_word[PRSC_STS_SELECTED] = use_secondary_reference;
        status_word[PRSC_STS_PRIMARY_PWR] = primary_reference_power;
        status_word[PRSC_STS_SECONDARY_PWR] = secondary_reference_power;
        status_word[PRSC_STS_AUTO_ON_SECONDARY] = (auto_state == PRSC_ON_SECONDARY);
        status_word[PRSC_STS_CONFIG_CONFLICT] = config_conflict;
        status_word[PRSC_STS_PRIMARY_OK] = primary_status_ok;
        status_word[PRSC_STS_SECONDARY_OK] = secondary_status_ok;
    end

    // Read data source for the bus slave.
    assign read_value = read_decode(read_addr, pll_reference_select_control, status_word);

    // Control register, written through byte lane 0 only; all fields reset to zero.
    always_ff @(posedge clock) begin
        if (rst) begin
            pll_reference_select_control <= PRSC_CONTROL_RESET;
        end else if (bus_req.wr && bus_req.lane0 && bus_req.addr == PRSC_ADDR_CONTROL) begin
            pll_reference_select_control <= bus_req.data;
        end
    end

    // Next automatic state: leave a failed primary, return only when allowed.
    always_comb begin
        next_auto_state = auto_state;
        if (!auto_mode) begin
            next_auto_state = PRSC_ON_PRIMARY;
        end else begin
            unique case (auto_state)
                PRSC_ON_PRIMARY: begin
                    if (!primary_status_ok) begin
                        next_auto_state = PRSC_ON_SECONDARY;
                    end
                end
                PRSC_ON_SECONDARY: begin
                    if (primary_status_ok && !stay_secondary) begin
                        next_auto_state = PRSC_ON_PRIMARY;
                    end
                end
                default: begin
                    next_auto_state = PRSC_ON_PRIMARY;
                end
            endcase
        end
    end

    // Automatic switchover state register.
    always_ff @(posedge clock) begin
        if (rst) begin
            auto_state <= PRSC_ON_PRIMARY;
        end else begin
            auto_state <= next_auto_state;
        end
    end

    // Reference choice: automatic state, or manual register bit or pin.
    // Using the next automatic state lets the select move on the same edge as the state.
    always_comb begin
        if (auto_mode) begin
            next_use_secondary = (next_auto_state == PRSC_ON_SECONDARY);
        end else if (pll_reference_select_control[PRSC_BIT_USE_PIN]) begin
            next_use_secondary = ref_sel_pin;
        end else begin
            next_use_secondary =
                pll_reference_select_control[PRSC_BIT_SELECT_SECONDARY];
        end
    end

    // Registered reference select output.
    always_ff @(posedge clock) begin
        if (rst) begin
            use_secondary_reference <= 1'b0;
        end else begin
            use_secondary_reference <= next_use_secondary;
        end
    end

    // Input power: automatic mode forces both on, otherwise the enable bits.
    // Both inputs stay powered in automatic mode so a recovered primary can be seen.
    always_ff @(posedge clock) begin
        if (rst) begin
            primary_reference_power <= 1'b0;
            secondary_reference_power <= 1'b0;
        end else if (auto_mode) begin
            primary_reference_power <= 1'b1;
            secondary_reference_power <= 1'b1;
        end else begin
            primary_reference_power <=
                pll_reference_select_control[PRSC_BIT_PRIMARY_PWR];
            secondary_reference_power <=
                pll_reference_select_control[PRSC_BIT_SECONDARY_PWR];
        end
    end

    // Checks on the switchover behaviour, all sampled on the rising clock.
    default clocking prsc_cb @(posedge clock);
    endclocking
    default disable iff (rst);

    // Register selection follows the select bit in manual mode.
    a_manual_reg_sel: assert property (
        !auto_mode && !pll_reference_select_control[PRSC_BIT_USE_PIN]
        |=> use_secondary_reference
            == $past(pll_reference_select_control[PRSC_BIT_SELECT_SECONDARY])
    ) else $error("Manual register select not followed.");

    // Pin selection follows the pin in manual mode.
    a_manual_pin_sel: assert property (
        !auto_mode && pll_reference_select_control[PRSC_BIT_USE_PIN]
        |=> use_secondary_reference == $past(ref_sel_pin)
    ) else $error("Manual pin select not followed.");

    // Automatic mode powers both inputs one cycle later.
    a_auto_power_on: assert property (
        auto_mode |=> primary_reference_power && secondary_reference_power
    ) else $error("Automatic mode did not power both inputs.");

    // Manual mode secondary power follows its bit.
    a_manual_sec_power: assert property (
        !auto_mode |=> secondary_reference_power
            == $past(pll_reference_select_control[PRSC_BIT_SECONDARY_PWR])
    ) else $error("Secondary power does not follow its bit.");

    // Manual mode primary power follows its bit.
    a_manual_pri_power: assert property (
        !auto_mode |=> primary_reference_power
            == $past(pll_reference_select_control[PRSC_BIT_PRIMARY_PWR])
    ) else $error("Primary power does not follow its bit.");

    // Reset leaves manual mode with the primary selected and primary power off.
    a_reset_manual: assert property (
        $fell(rst) |-> !auto_mode && !use_secondary_reference && !primary_reference_power
    ) else $error("Reset did not leave manual mode.");

    // A failed primary moves an automatic block to the secondary next cycle.
    a_fail_to_sec: assert property (
        auto_mode && auto_state == PRSC_ON_PRIMARY && !primary_status_ok
        |=> use_secondary_reference && auto_state == PRSC_ON_SECONDARY
    ) else $error("Failed primary not left.");

    // A recovered primary is taken back when revert is allowed.
    a_revert_primary: assert property (
        auto_mode && auto_state == PRSC_ON_SECONDARY && primary_status_ok && !stay_secondary
        |=> !use_secondary_reference
    ) else $error("Recovered primary not taken back.");

    // With the stay bit set the secondary is held while automatic mode lasts.
    a_stay_secondary: assert property (
        auto_mode && stay_secondary && auto_state == PRSC_ON_SECONDARY
        ##1 auto_mode && stay_secondary
        |-> use_secondary_reference && auto_state == PRSC_ON_SECONDARY
    ) else $error("Stay on secondary not kept.");

    // A status read reports automatic mode combined with differential mode.
    a_conflict_flag: assert property (
        read_addr == PRSC_ADDR_STATUS
        |-> read_value[PRSC_STS_CONFIG_CONFLICT]
            == (auto_mode && pll_reference_select_control[PRSC_BIT_DIFF_MODE])
    ) else $error("Configuration conflict flag wrong.");

    // Leaving automatic mode puts the state machine back on the primary.
    a_leave_auto_primary: assert property (
        !auto_mode |=> auto_state == PRSC_ON_PRIMARY
    ) else $error("Manual mode did not reset the automatic state.");

    // In automatic mode the select bit and the pin are ignored.
    a_auto_ignores_sel: assert property (
        auto_mode |=> use_secondary_reference == (auto_state == PRSC_ON_SECONDARY)
    ) else $error("Automatic mode followed a manual select.");

    // A good primary is kept while automatic mode runs on it.
    a_keep_good_primary: assert property (
        auto_mode && auto_state == PRSC_ON_PRIMARY && primary_status_ok
        |=> auto_state == PRSC_ON_PRIMARY
    ) else $error("Good primary left.");

    // A primary that is still bad never takes the reference back.
    a_wait_for_primary: assert property (
        auto_mode && auto_state == PRSC_ON_SECONDARY && !primary_status_ok
        |=> auto_state == PRSC_ON_SECONDARY
    ) else $error("Returned to a failed primary.");

    // An accepted write to the control register lands in one edge.
    a_write_lands: assert property (
        bus_req.wr && bus_req.lane0 && bus_req.addr == PRSC_ADDR_CONTROL
        |=> pll_reference_select_control == $past(bus_req.data)
    ) else $error("Control write did not land.");

    // A write without byte lane 0 leaves the control register alone.
    a_masked_write: assert property (
        bus_req.wr && !bus_req.lane0 |=> $stable(pll_reference_select_control)
    ) else $error("Masked write changed the control register.");

    // A write to any other address leaves the control register alone.
    a_unmapped_write: assert property (
        bus_req.wr && bus_req.addr != PRSC_ADDR_CONTROL
        |=> $stable(pll_reference_select_control)
    ) else $error("Foreign write changed the control register.");

    // Main scenarios.
    c_fail_over: cover property (
        auto_mode && auto_state == PRSC_ON_PRIMARY ##1 auto_state == PRSC_ON_SECONDARY
    );
    c_revert: cover property (
        auto_state == PRSC_ON_SECONDARY && auto_mode ##1 auto_state == PRSC_ON_PRIMARY
    );
    c_pin_select: cover property (
        !auto_mode && pll_reference_select_control[PRSC_BIT_USE_PIN] && use_secondary_reference
    );
    c_reg_write: cover property (
        bus_req.wr && bus_req.addr == PRSC_ADDR_CONTROL
    );
    c_stay_held: cover property (
        auto_mode && stay_secondary && primary_status_ok && auto_state == PRSC_ON_SECONDARY
    );

endmodule // prsc_switchover

// ===== sim/prsc_ref_sources.sv
// Model of the two external reference sources and the reference select pin.
// Assumes the bench commands each source's health and the pin level at clock edges.
`timescale 1ns/10ps
module prsc_ref_sources (
    input wire logic clock,
    input wire logic rst,
    input wire logic cmd_pin,
    input wire logic cmd_primary_good,
    input wire logic cmd_secondary_good,
    output logic ref_sel_pin,
    output logic primary_status_ok,
    output logic secondary_status_ok
);
    // Monitors report through a register stage, one edge after the source changes.
    always_ff @(posedge clock) begin
        if (rst) begin
            ref_sel_pin <= 1'b0;
            primary_status_ok <= 1'b1;
            secondary_status_ok <= 1'b1;
        end else begin
            ref_sel_pin <= cmd_pin;
            primary_status_ok <= cmd_primary_good;
            secondary_status_ok <= cmd_secondary_good;
        end
    end
endmodule // prsc_ref_sources

// ===== sim/prsc_switchover_tb.sv
// Self-checking bench for the reference switchover control block.
// Assumes the design answers each register access after a bounded number of cycles.
`timescale 1ns/10ps
module prsc_switchover_tb;
    import prsc_pkg::*;
    logic clock, rst, avs_read, avs_write, avs_waitrequest;
    logic [7:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [3:0] avs_byteenable;
    logic cmd_pin, cmd_primary_good, cmd_secondary_good;
    logic ref_sel_pin, primary_status_ok, secondary_status_ok;
    logic use_secondary_reference, primary_reference_power, secondary_reference_power;
    int fail_count, num_checks;

    prsc_switchover dut (.clock(clock), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .ref_sel_pin(ref_sel_pin),
        .primary_status_ok(primary_status_ok), .secondary_status_ok(secondary_status_ok),
        .use_secondary_reference(use_secondary_reference),
        .primary_reference_power(primary_reference_power),
        .secondary_reference_power(secondary_reference_power));

    prsc_ref_sources sources (.clock(clock), .rst(rst), .cmd_pin(cmd_pin),
        .cmd_primary_good(cmd_primary_good), .cmd_secondary_good(cmd_secondary_good),
        .ref_sel_pin(ref_sel_pin), .primary_status_ok(primary_status_ok),
        .secondary_status_ok(secondary_status_ok));

    // Free-running 25 MHz clock.
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Compares one value and reports a mismatch at once.
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", name, exp, got);
            fail_count++;
        end
    endtask

    // One Avalon access held until waitrequest is sampled low.
    task automatic bus(input logic wr, input logic [7:0] addr, input logic [7:0] data,
                       input logic [3:0] be);
        int n;
        n = 0;
        avs_address <= addr;
        avs_writedata <= {24'h000000, data};
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= ~wr;
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clock);
        if (n >= 20) begin
            $display("mismatch waitrequest expected 0 seen %b", avs_waitrequest);
            fail_count++;
            conclude();
        end
    endtask

    // Writes the control register and waits until the outputs follow.
    task automatic set_ctrl(input logic [7:0] value);
        bus(1'b1, PRSC_ADDR_CONTROL, value, 4'hF);
        repeat (2) @(posedge clock);
    endtask

    // Checks the three reference outputs against select, primary and secondary power.
    task automatic outs(input logic sel, input logic pp, input logic sp);
        check("use_secondary_reference", {31'h0, sel}, {31'h0, use_secondary_reference});
        check("primary_reference_power", {31'h0, pp}, {31'h0, primary_reference_power});
        check("secondary_reference_power", {31'h0, sp}, {31'h0, secondary_reference_power});
    endtask

    // Reset defaults of outputs and control register, then unmapped and masked writes.
    task automatic t_reset_and_map();
        outs(1'b0, 1'b0, 1'b0);
        bus(1'b0, PRSC_ADDR_CONTROL, 8'h00, 4'hF);
        check("control reset", {24'h0, PRSC_CONTROL_RESET}, rd);
        bus(1'b1, 8'h40, 8'h46, 4'hF);
        bus(1'b0, 8'h40, 8'h00, 4'hF);
        check("unmapped read", PRSC_UNMAPPED_DATA, rd);
        bus(1'b1, PRSC_ADDR_CONTROL, 8'h46, 4'hE);
        bus(1'b0, PRSC_ADDR_CONTROL, 8'h00, 4'hF);
        check("masked write", 32'h00000000, rd);
        outs(1'b0, 1'b0, 1'b0);
    endtask

    // Manual selection by register bit and by pin, with the power bits alone.
    task automatic t_manual();
        set_ctrl(8'h46);
        outs(1'b1, 1'b1, 1'b1);
        bus(1'b0, PRSC_ADDR_CONTROL, 8'h00, 4'hF);
        check("control readback", 32'h00000046, rd);
        set_ctrl(8'h02);
        outs(1'b0, 1'b1, 1'b0);
        set_ctrl(8'h64);
        outs(1'b0, 1'b0, 1'b1);
        cmd_pin <= 1'b1;
        repeat (3) @(posedge clock);
        check("pin selects secondary", 32'h1, {31'h0, use_secondary_reference});
        set_ctrl(8'h04);
        check("register overrides pin", 32'h0, {31'h0, use_secondary_reference});
        cmd_pin <= 1'b0;
        set_ctrl(8'h00);
        outs(1'b0, 1'b0, 1'b0);
    endtask

    // Automatic mode: forced power, failover, revert, and stay on secondary.
    task automatic t_auto(input logic stay);
        set_ctrl({4'h5, stay, 3'b000}); // Differential bit kept clear first.
        outs(1'b0, 1'b1, 1'b1);
        cmd_pin <= 1'b1;
        cmd_primary_good <= 1'b0;
        cmd_secondary_good <= stay;
        repeat (3) @(posedge clock);
        outs(1'b1, 1'b1, 1'b1);
        bus(1'b0, PRSC_ADDR_STATUS, 8'h00, 4'hF);
        check("status on secondary", {24'h0, 1'b0, stay, 6'h0F}, rd);
        cmd_primary_good <= 1'b1;
        cmd_secondary_good <= 1'b1;
        repeat (3) @(posedge clock);
        check("revert or stay", {31'h0, stay}, {31'h0, use_secondary_reference});
        cmd_pin <= 1'b0;
        set_ctrl(8'h00);
        outs(1'b0, 1'b0, 1'b0);
    endtask

    // Main sequence with a global time limit.
    initial begin
        fail_count = 0;
        num_checks = 0;
        rst = 1'b1;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h00000000;
        avs_byteenable = 4'hF;
        cmd_pin = 1'b0;
        cmd_primary_good = 1'b1;
        cmd_secondary_good = 1'b1;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        t_reset_and_map();
        t_manual();
        t_auto(1'b0);
        t_auto(1'b1);
        conclude();
    end

    // Cuts a hang short.
    initial begin
        #200000;
        fail_count++;
        conclude();
    end
endmodule // prsc_switchover_tb
